// ### hw/dpmm_pkg.sv
// Constants for the dual pointer and data memory map block
package dpmm_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0]  AUX1_INDEX = 8'ha2;
  localparam logic [7:0]  AUX_INDEX  = 8'h8e;
  localparam logic [7:0]  PTR_INDEX  = 8'h82;
  localparam logic [11:0] AUX1_ADDR  = {2'h0, AUX1_INDEX, 2'h0};
  localparam logic [11:0] AUX_ADDR   = {2'h0, AUX_INDEX, 2'h0};
  localparam logic [11:0] PTR_ADDR   = {2'h0, PTR_INDEX, 2'h0};

  // auxiliary_control_one fields
  localparam int SEL_BIT  = 0;
  localparam int FLAG_BIT = 3;
  localparam int BOOT_BIT = 5;

  // auxiliary_control fields
  localparam int         AUX_EXT_BIT  = 1;
  localparam int         AUX_SIZE_LSB = 2;
  localparam int         SIZE_W       = 3;
  localparam logic [7:0] AUX_RESET    = 8'h08;
  localparam logic [7:0] AUX_WMASK    = 8'hbf;

  // Expanded RAM size codes and the first address above each size
  localparam logic [2:0]  SIZE_256    = 3'h0;
  localparam logic [2:0]  SIZE_512    = 3'h1;
  localparam logic [2:0]  SIZE_768    = 3'h2;
  localparam logic [2:0]  SIZE_1024   = 3'h3;
  localparam logic [15:0] LIMIT_256   = 16'h0100;
  localparam logic [15:0] LIMIT_512   = 16'h0200;
  localparam logic [15:0] LIMIT_768   = 16'h0300;
  localparam logic [15:0] LIMIT_1024  = 16'h0400;
  localparam logic [15:0] LIMIT_1792  = 16'h0700;

  // Code and internal data map
  localparam logic [15:0] BOOT_BASE = 16'hf800;
  localparam int          UPPER_BIT = 7;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ### hw/dpmm_pointer.sv
// One 16-bit data pointer with load and increment
`timescale 1ns/1ns
module dpmm_pointer
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstLocal_b,
  // Control
  input  wire logic        selected,
  input  wire logic        load,
  input  wire logic [15:0] loadValue,
  input  wire logic        increment,
  // State
  output logic      [15:0] value
);

  logic [15:0] next_value;

  assign next_value = !selected ? value :
                      load      ? loadValue :
                      increment ? value + 16'h0001 :
                                  value;

  always_ff @(posedge clock or negedge rstLocal_b)
  begin
    if (!rstLocal_b)
      value <= 16'h0000;
    else
      value <= next_value;
  end

endmodule

// ### hw/dpmm_top.sv
// Dual data pointer, boot map and internal/external data decode
`timescale 1ns/1ns
// Behaviour
// - Two 16-bit pointers, bit 0 selects
// - Bit 5 maps boot ROM at F800h-FFFFh
// - Bit 2 reads zero; increment toggles select
// - Lower RAM reached directly and indirectly
// - Indirect upper addresses reach upper RAM
// - Direct upper addresses reach function registers
// - Select clear: moves reach expanded RAM
// - Size field hides RAM, rest goes out
// - Select set: all moves go external
module dpmm_top
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // AXI4-Lite write
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Core pointer operations
  input  wire logic        ptrLoad,
  input  wire logic [15:0] ptrLoadValue,
  input  wire logic        ptrInc,
  input  wire logic        auxOneInc,
  // Core external-data move
  input  wire logic        moveReq,
  input  wire logic        moveUsePointer,
  input  wire logic [7:0]  moveRegAddr,
  output logic      [15:0] moveAddr,
  output logic             moveToExpRam,
  output logic             moveToBus,
  // Core internal data access
  input  wire logic        dataReq,
  input  wire logic        dataIndirect,
  input  wire logic [7:0]  dataAddr,
  output logic             lowRamSel,
  output logic             upperRamSel,
  output logic             sfrSel,
  // Code fetch
  input  wire logic [15:0] codeAddr,
  output logic             bootRomSelect
);

  ////////////////////////////////////////////////////////////////////////////
  logic        rstSync1;
  logic        rstLocal_b;
  logic        awGot;
  logic        wGot;
  logic [11:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0]  wStrbHeld;
  logic        pointerSelect;
  logic        userFlag;
  logic        bootRomMapEnable;
  logic [7:0]  auxCtl;
  logic [15:0] firstPointer;
  logic [15:0] secondPointer;

  wire         awTake = awvalid & awready;
  wire         wTake  = wvalid & wready;
  wire         arTake = arvalid & arready;
  wire         doWrite = awGot & wGot & ~bvalid;
  wire         wHitAux1 = awAddrHeld == dpmm_pkg::AUX1_ADDR;
  wire         wHitAux  = awAddrHeld == dpmm_pkg::AUX_ADDR;
  wire         wHitPtr  = awAddrHeld == dpmm_pkg::PTR_ADDR;
  wire         wMapped  = wHitAux1 | wHitAux | wHitPtr;
  wire         rHitAux1 = araddr == dpmm_pkg::AUX1_ADDR;
  wire         rHitAux  = araddr == dpmm_pkg::AUX_ADDR;
  wire         rHitPtr  = araddr == dpmm_pkg::PTR_ADDR;
  wire         auxOneWrite = doWrite & wHitAux1 & wStrbHeld[0];
  wire         auxWrite    = doWrite & wHitAux & wStrbHeld[0];
  wire         busPtrLoad  = doWrite & wHitPtr & (|wStrbHeld[1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstSync1   <= 1'b0;
      rstLocal_b <= 1'b0;
    end
    else
    begin
      rstSync1   <= 1'b1;
      rstLocal_b <= rstSync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register views
  wire [15:0] activePointer = pointerSelect ? secondPointer : firstPointer;
  wire [7:0]  auxOneView = {2'b00, bootRomMapEnable, 1'b0,
                            userFlag, 1'b0, 1'b0, pointerSelect};
  wire [31:0] readWord = rHitAux1 ? {24'h000000, auxOneView} :
                         rHitAux  ? {24'h000000, auxCtl} :
                         rHitPtr  ? {16'h0000, activePointer} :
                                    32'h00000000;
  wire [15:0] busPtrValue =
    {wStrbHeld[1] ? wDataHeld[15:8] : activePointer[15:8],
     wStrbHeld[0] ? wDataHeld[7:0]  : activePointer[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel
  always_ff @(posedge clock or negedge rstLocal_b)
  begin
    if (!rstLocal_b)
    begin
      awGot      <= 1'b0;
      awready    <= 1'b0;
      awAddrHeld <= 12'h000;
    end
    else if (awTake)
    begin
      awGot      <= 1'b1;
      awready    <= 1'b0;
      awAddrHeld <= awaddr;
    end
    else
    begin
      awGot   <= awGot & ~doWrite;
      awready <= ~awGot & ~bvalid;
    end
  end

  always_ff @(posedge clock or negedge rstLocal_b)
  begin
    if (!rstLocal_b)
    begin
      wGot      <= 1'b0;
      wready    <= 1'b0;
      wDataHeld <= 32'h00000000;
      wStrbHeld <= 4'h0;
    end
    else if (wTake)
    begin
      wGot      <= 1'b1;
      wready    <= 1'b0;
      wDataHeld <= wdata;
      wStrbHeld <= wstrb;
    end
    else
    begin
      wGot   <= wGot & ~doWrite;
      wready <= ~wGot & ~bvalid;
    end
  end

  always_ff @(posedge clock or negedge rstLocal_b)
  begin
    if (!rstLocal_b)
    begin
      bvalid <= 1'b0;
      bresp  <= dpmm_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      bresp  <= wMapped ? dpmm_pkg::RESP_OKAY : dpmm_pkg::RESP_DECERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel
  always_ff @(posedge clock or negedge rstLocal_b)
  begin
    if (!rstLocal_b)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= dpmm_pkg::RESP_OKAY;
    end
    else if (arTake)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= readWord;
      rresp   <= (rHitAux1 | rHitAux | rHitPtr) ? dpmm_pkg::RESP_OKAY
                                                : dpmm_pkg::RESP_DECERR;
    end
    else
    begin
      rvalid  <= rvalid & ~rready;
      arready <= ~rvalid & ~arready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; a bus write wins over a core increment
  always_ff @(posedge clock or negedge rstLocal_b)
  begin
    if (!rstLocal_b)
    begin
      pointerSelect    <= 1'b0;
      userFlag         <= 1'b0;
      bootRomMapEnable <= 1'b0;
    end
    else if (auxOneWrite)
    begin
      pointerSelect    <= wDataHeld[dpmm_pkg::SEL_BIT];
      userFlag         <= wDataHeld[dpmm_pkg::FLAG_BIT];
      bootRomMapEnable <= wDataHeld[dpmm_pkg::BOOT_BIT];
    end
    else if (auxOneInc)
      pointerSelect <= ~pointerSelect;
  end

  always_ff @(posedge clock or negedge rstLocal_b)
  begin
    if (!rstLocal_b)
      auxCtl <= dpmm_pkg::AUX_RESET;
    else if (auxWrite)
      auxCtl <= wDataHeld[7:0] & dpmm_pkg::AUX_WMASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointers; core load wins over a bus load
  wire        anyLoad   = ptrLoad | busPtrLoad;
  wire [15:0] loadValue = ptrLoad ? ptrLoadValue : busPtrValue;

  dpmm_pointer u_first
  (
    .clock      (clock),
    .rstLocal_b (rstLocal_b),
    .selected   (~pointerSelect),
    .load       (anyLoad),
    .loadValue  (loadValue),
    .increment  (ptrInc),
    .value      (firstPointer)
  );

  dpmm_pointer u_second
  (
    .clock      (clock),
    .rstLocal_b (rstLocal_b),
    .selected   (pointerSelect),
    .load       (anyLoad),
    .loadValue  (loadValue),
    .increment  (ptrInc),
    .value      (secondPointer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Memory decode
  wire [2:0]  sizeCode = auxCtl[dpmm_pkg::AUX_SIZE_LSB +: dpmm_pkg::SIZE_W];
  wire        extSelect = auxCtl[dpmm_pkg::AUX_EXT_BIT];
  wire [15:0] expRamLimit =
    (sizeCode == dpmm_pkg::SIZE_256)  ? dpmm_pkg::LIMIT_256 :
    (sizeCode == dpmm_pkg::SIZE_512)  ? dpmm_pkg::LIMIT_512 :
    (sizeCode == dpmm_pkg::SIZE_768)  ? dpmm_pkg::LIMIT_768 :
    (sizeCode == dpmm_pkg::SIZE_1024) ? dpmm_pkg::LIMIT_1024 :
                                        dpmm_pkg::LIMIT_1792;
  wire [15:0] next_moveAddr = moveUsePointer ? activePointer
                                             : {8'h00, moveRegAddr};
  wire        inExpRam = ~extSelect & (next_moveAddr < expRamLimit);
  wire        upperHalf = dataAddr[dpmm_pkg::UPPER_BIT];

  always_ff @(posedge clock or negedge rstLocal_b)
  begin
    if (!rstLocal_b)
    begin
      moveAddr      <= 16'h0000;
      moveToExpRam  <= 1'b0;
      moveToBus     <= 1'b0;
      lowRamSel     <= 1'b0;
      upperRamSel   <= 1'b0;
      sfrSel        <= 1'b0;
      bootRomSelect <= 1'b0;
    end
    else
    begin
      moveAddr      <= next_moveAddr;
      moveToExpRam  <= moveReq & inExpRam;
      moveToBus     <= moveReq & ~inExpRam;
      lowRamSel     <= dataReq & ~upperHalf;
      upperRamSel   <= dataReq & upperHalf & dataIndirect;
      sfrSel        <= dataReq & upperHalf & ~dataIndirect;
      bootRomSelect <= bootRomMapEnable &
                       (codeAddr >= dpmm_pkg::BOOT_BASE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstLocal_b);

  a_ptr_increment: assert property (
    ptrInc & ~anyLoad & ~pointerSelect |=>
      firstPointer == $past(firstPointer) + 16'h0001)
    else $error("Selected first pointer did not increment");
  a_other_pointer: assert property (
    ~pointerSelect |=> secondPointer == $past(secondPointer))
    else $error("Unselected second pointer changed");
  a_boot_window: assert property (
    bootRomMapEnable && codeAddr >= 16'hf800 |=> bootRomSelect)
    else $error("Boot ROM not mapped");
  a_boot_off: assert property (
    ~bootRomMapEnable |=> ~bootRomSelect)
    else $error("Boot ROM mapped while disabled");
  a_inc_toggle: assert property (
    auxOneInc & ~auxOneWrite |=> pointerSelect != $past(pointerSelect)
      && userFlag == $past(userFlag))
    else $error("Increment did not toggle select only");
  a_lower_ram: assert property (
    dataReq & ~dataAddr[7] |=> lowRamSel & ~upperRamSel & ~sfrSel)
    else $error("Lower RAM not selected");
  a_upper_ram: assert property (
    dataReq & dataAddr[7] & dataIndirect |=> upperRamSel & ~sfrSel)
    else $error("Indirect upper access missed upper RAM");
  a_sfr_direct: assert property (
    dataReq & dataAddr[7] & ~dataIndirect |=> sfrSel & ~upperRamSel)
    else $error("Direct upper access missed registers");
  a_exp_ram: assert property (
    moveReq & ~extSelect & ~moveUsePointer |=> moveToExpRam & ~moveToBus)
    else $error("Register move missed expanded RAM");
  a_size_hide: assert property (
    moveReq & ~extSelect & moveUsePointer & (sizeCode == 3'h0)
      & (activePointer[15:8] != 8'h00) |=> moveToBus & ~moveToExpRam)
    else $error("Move above size not sent out");
  a_ext_select: assert property (
    moveReq & extSelect |=> moveToBus & ~moveToExpRam)
    else $error("External select ignored");
  a_bresp_hold: assert property (
    bvalid & ~bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped");

  c_exp_ram: cover property (moveReq & ~extSelect ##1 moveToExpRam);
  c_boot_map: cover property (bootRomSelect);
  c_two_inc: cover property (auxOneInc ##1 auxOneInc);
  c_bus_read: cover property (arTake ##1 rvalid & rready);

endmodule

// ### test/tb_dpmm_top.sv
// Self-checking testbench for the dual pointer and data memory map block
`timescale 1ns/1ns
module tb_dpmm_top;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        ptrLoad = 1'b0, ptrInc = 1'b0, auxOneInc = 1'b0;
  logic [15:0] ptrLoadValue = 16'h0000;
  logic        moveReq = 1'b0, moveUsePointer = 1'b0;
  logic [7:0]  moveRegAddr = 8'h00;
  logic [15:0] moveAddr;
  logic        moveToExpRam, moveToBus;
  logic        dataReq = 1'b0, dataIndirect = 1'b0;
  logic [7:0]  dataAddr = 8'h00;
  logic        lowRamSel, upperRamSel, sfrSel;
  logic [15:0] codeAddr = 16'h0000;
  logic        bootRomSelect;
  int          err_total = 0;
  int          check_count = 0;
  logic [1:0]  resp;
  logic [31:0] rd;

  always #4 clock = ~clock;

  dpmm_top dpmm_top_inst
  (
    .clock(clock), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ptrLoad(ptrLoad), .ptrLoadValue(ptrLoadValue), .ptrInc(ptrInc),
    .auxOneInc(auxOneInc),
    .moveReq(moveReq), .moveUsePointer(moveUsePointer),
    .moveRegAddr(moveRegAddr), .moveAddr(moveAddr),
    .moveToExpRam(moveToExpRam), .moveToBus(moveToBus),
    .dataReq(dataReq), .dataIndirect(dataIndirect), .dataAddr(dataAddr),
    .lowRamSel(lowRamSel), .upperRamSel(upperRamSel), .sfrSel(sfrSel),
    .codeAddr(codeAddr), .bootRomSelect(bootRomSelect)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic timedOut;
    err_total++;
    $display("MISMATCH t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    tally_and_finish();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus tasks, entered just after a rising edge
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
                          output logic [1:0] r);
    int   n;
    logic awOpen, wOpen;
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    awOpen = 1'b1; wOpen = 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock);
      if (bvalid === 1'b1) break;
      if (awOpen && awready === 1'b1) begin awOpen = 0; awvalid <= 1'b0; end
      if (wOpen && wready === 1'b1) begin wOpen = 0; wvalid <= 1'b0; end
    end
    if (n == 50) timedOut();
    r = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock);
      if (rvalid === 1'b1) break;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    if (n == 50) timedOut();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic regWrite(input logic [11:0] a, input logic [31:0] d);
    axiWrite(a, d, resp);
    check(resp, dpmm_pkg::RESP_OKAY);
  endtask

  task automatic regCheck(input logic [11:0] a, input logic [31:0] e);
    axiRead(a, rd, resp);
    check(resp, dpmm_pkg::RESP_OKAY);
    check(rd, e);
  endtask

  task automatic loadPtr(input logic [15:0] v);
    ptrLoad <= 1'b1; ptrLoadValue <= v;
    @(posedge clock);
    ptrLoad <= 1'b0;
  endtask

  task automatic doMove(input logic u, input logic [7:0] ra,
                        input logic [15:0] ea, input logic toExp);
    moveReq <= 1'b1; moveUsePointer <= u; moveRegAddr <= ra;
    @(posedge clock);
    moveReq <= 1'b0;
    #1;
    check({moveAddr, moveToExpRam, moveToBus}, {ea, toExp, ~toExp});
    @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic testRegs;
    regCheck(dpmm_pkg::AUX1_ADDR, 32'h0);
    regCheck(dpmm_pkg::AUX_ADDR, {24'h0, dpmm_pkg::AUX_RESET});
    axiRead(12'h004, rd, resp);
    check({resp, rd[29:0]}, {dpmm_pkg::RESP_DECERR, 30'h0});
    axiWrite(12'h004, 32'hff, resp);
    check(resp, dpmm_pkg::RESP_DECERR);
    regWrite(dpmm_pkg::AUX_ADDR, 32'hff);
    regCheck(dpmm_pkg::AUX_ADDR, 32'hbf);
    regWrite(dpmm_pkg::AUX_ADDR, {24'h0, dpmm_pkg::AUX_RESET});
    $display("test registers done");
  endtask

  task automatic testAuxOne;
    regWrite(dpmm_pkg::AUX1_ADDR, 32'h2d);
    regCheck(dpmm_pkg::AUX1_ADDR, 32'h29);
    auxOneInc <= 1'b1;
    @(posedge clock);
    auxOneInc <= 1'b0;
    regCheck(dpmm_pkg::AUX1_ADDR, 32'h28);
    regWrite(dpmm_pkg::AUX1_ADDR, 32'h0);
    $display("test aux one done");
  endtask

  task automatic testPointers;
    loadPtr(16'h1234);
    regWrite(dpmm_pkg::AUX1_ADDR, 32'h1);
    loadPtr(16'h00ff);
    ptrInc <= 1'b1;
    @(posedge clock);
    ptrInc <= 1'b0;
    regCheck(dpmm_pkg::PTR_ADDR, 32'h0100);
    regWrite(dpmm_pkg::PTR_ADDR, 32'habcd);
    regCheck(dpmm_pkg::PTR_ADDR, 32'habcd);
    regWrite(dpmm_pkg::AUX1_ADDR, 32'h0);
    regCheck(dpmm_pkg::PTR_ADDR, 32'h1234);
    doMove(1'b1, 8'h00, 16'h1234, 1'b0);
    $display("test pointers done");
  endtask

  task automatic testBoot;
    logic [15:0] addrs [4] = '{16'hf7ff, 16'hf800, 16'hffff, 16'hffff};
    logic        exps [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    regWrite(dpmm_pkg::AUX1_ADDR, 32'h20);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3) regWrite(dpmm_pkg::AUX1_ADDR, 32'h0);
      codeAddr <= addrs[i];
      @(posedge clock);
      #1;
      check(bootRomSelect, exps[i]);
      @(posedge clock);
    end
    $display("test boot map done");
  endtask

  task automatic testDataMap;
    logic [7:0] addrs [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
    for (int i = 0; i < 8; i++)
    begin
      dataReq <= 1'b1; dataIndirect <= i[0]; dataAddr <= addrs[i / 2];
      @(posedge clock);
      dataReq <= 1'b0;
      #1;
      check({lowRamSel, upperRamSel, sfrSel},
            (i < 4) ? 3'b100 : (i[0] ? 3'b010 : 3'b001));
      @(posedge clock);
    end
    $display("test data map done");
  endtask

  task automatic testMoves;
    logic [15:0] limits [5] = '{dpmm_pkg::LIMIT_256, dpmm_pkg::LIMIT_512,
      dpmm_pkg::LIMIT_768, dpmm_pkg::LIMIT_1024, dpmm_pkg::LIMIT_1792};
    doMove(1'b0, 8'ha0, 16'h00a0, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      regWrite(dpmm_pkg::AUX_ADDR, i << 2);
      loadPtr(limits[i] - 16'h1);
      doMove(1'b1, 8'h00, limits[i] - 16'h1, 1'b1);
      loadPtr(limits[i]);
      doMove(1'b1, 8'h00, limits[i], 1'b0);
    end
    regWrite(dpmm_pkg::AUX_ADDR, 32'h12);
    doMove(1'b0, 8'h00, 16'h0000, 1'b0);
    regWrite(dpmm_pkg::AUX_ADDR, {24'h0, dpmm_pkg::AUX_RESET});
    $display("test moves done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (5) @(posedge clock);
    testRegs();
    testAuxOne();
    testPointers();
    testBoot();
    testDataMap();
    testMoves();
    tally_and_finish();
  end
endmodule
